// ===== src/perf_event_pkg.sv
/*
 * Shared constants and carriers for the performance event selector:
 * event codes, unit masks, counter geometry, reset values and the
 * packed structs that carry the counter selections and the event strobes.
 * Assumes every strobe is a single-cycle pulse from logic on the core clock.
 */
package perf_event_pkg;

    localparam int         NUM_CTR         = 2;
    localparam int         CTR_W           = 40;
    localparam int         ID_W            = 8;
    localparam int         CTR_ZERO_IDX    = 0;

    // event codes
    localparam logic [7:0] EVT_DTLB_MISS   = 8'h08;
    localparam logic [7:0] EVT_DISAMBIG    = 8'h09;
    localparam logic [7:0] EVT_PAGE_WALK   = 8'h0C;
    localparam logic [7:0] EVT_FP_COMPUTE  = 8'h10;
    localparam logic [7:0] EVT_FP_HELP     = 8'h11;
    localparam logic [7:0] EVT_MULTIPLY    = 8'h12;

    // unit masks
    localparam logic [7:0] UM_NONE         = 8'h00;
    localparam logic [7:0] UM_STORE_MISS   = 8'h08;
    localparam logic [7:0] UM_DIS_RESET    = 8'h01;
    localparam logic [7:0] UM_DIS_SUCCESS  = 8'h02;
    localparam logic [7:0] UM_WALK_COUNT   = 8'h01;
    localparam logic [7:0] UM_WALK_CYCLES  = 8'h02;

    // values after reset
    localparam logic [CTR_W-1:0] CTR_RESET = 40'h00_0000_0000;
    localparam logic [ID_W-1:0]  ID_RESET  = 8'h00;

    typedef struct packed {
        logic       enable;
        logic [7:0] event_code;
        logic [7:0] unit_mask;
    } ctr_sel_t;

    typedef struct packed {
        logic            store_translation_miss_event;
        logic            load_order_speculation_success;
        logic            disamb_mispredict;
        logic [ID_W-1:0] disamb_load_id;
        logic            disamb_restart_done;
        logic            walk_start_dtlb;
        logic            walk_start_itlb;
        logic            walk_done;
        logic            float_compute_uop_event;
        logic            vec_denormal_input;
        logic            vec_underflow_result;
        logic            denormal_input_zeroing_flag;
        logic            underflow_result_zeroing_flag;
        logic            stack_nan_or_denormal_load;
        logic            stack_divide_by_zero;
        logic            stack_underflow_output;
        logic            multiply_event_int;
        logic            multiply_event_float;
    } core_events_t;

endpackage : perf_event_pkg

// ===== src/perf_event_select_decoder.sv
/*
 * Event selector and counter-increment logic for two general counters.
 * Each counter is steered by a programmed event code and unit mask pair;
 * the matching strobe advances it, except that float compute uops count on
 * counter zero only and float assists on counter one only. Also tracks the
 * disambiguation recovery window and the page walk window, and raises the
 * pipeline flush.
 * Assumes all inputs come from logic on ref_clk; no synchronisers needed.
 */
`timescale 1ns/1ns

module perf_event_select_decoder
    import perf_event_pkg::*;
(
    input  logic                            ref_clk,
    input  logic                            rst_b,
    input  ctr_sel_t [NUM_CTR-1:0]          counter_select,
    input  core_events_t                    events,
    output logic [NUM_CTR-1:0][CTR_W-1:0]   count_value,
    output logic                            pipe_flush,
    output logic [ID_W-1:0]                 restart_load_id,
    output logic                            disamb_busy,
    output logic                            walk_busy
);

    logic                   disamb_busy_reg;
    logic                   walk_busy_reg;
    logic                   pipe_flush_reg;
    logic [ID_W-1:0]        restart_id_reg;
    logic                   walk_start;
    logic                   float_microcode_help_event;
    logic [1:0]             inc [NUM_CTR];
    logic [CTR_W-1:0]       ctr_reg [NUM_CTR];

    assign walk_start = events.walk_start_dtlb | events.walk_start_itlb;

    // vector cases depend on the zeroing flags, stack cases do not
    assign float_microcode_help_event =
        (events.vec_denormal_input & ~events.denormal_input_zeroing_flag) |
        (events.vec_underflow_result & ~events.underflow_result_zeroing_flag) |
        events.stack_nan_or_denormal_load |
        events.stack_divide_by_zero |
        events.stack_underflow_output;

    // recovery window opens on a mispredict; a new one wins over done
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            disamb_busy_reg <= 1'b0;
        end else if (events.disamb_mispredict) begin
            disamb_busy_reg <= 1'b1;
        end else if (events.disamb_restart_done) begin
            disamb_busy_reg <= 1'b0;
        end
    end

    // flush is a one-cycle request carrying the load to restart from
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pipe_flush_reg <= 1'b0;
            restart_id_reg <= ID_RESET;
        end else begin
            pipe_flush_reg <= events.disamb_mispredict;
            if (events.disamb_mispredict) begin
                restart_id_reg <= events.disamb_load_id;
            end
        end
    end

    // back-to-back walks: a start in the done cycle keeps the window open
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            walk_busy_reg <= 1'b0;
        end else if (walk_start) begin
            walk_busy_reg <= 1'b1;
        end else if (events.walk_done) begin
            walk_busy_reg <= 1'b0;
        end
    end

    assign pipe_flush      = pipe_flush_reg;
    assign restart_load_id = restart_id_reg;
    assign disamb_busy     = disamb_busy_reg;
    assign walk_busy       = walk_busy_reg;

    function automatic logic [1:0] event_increment(
        input ctr_sel_t     sel,
        input logic         is_zero,
        input core_events_t e,
        input logic         walk_on,
        input logic         walk_go,
        input logic         dis_on,
        input logic         help
    );
        logic [1:0] step;
        step = 2'h0;
        if (sel.enable) begin
            case ({sel.event_code, sel.unit_mask})
                // no retire qualifier: speculative misses count as well
                {EVT_DTLB_MISS, UM_STORE_MISS}: begin
                    step = {1'b0, e.store_translation_miss_event};
                end
                {EVT_DISAMBIG, UM_DIS_RESET}: begin
                    step = {1'b0, dis_on};
                end
                {EVT_DISAMBIG, UM_DIS_SUCCESS}: begin
                    step = {1'b0, e.load_order_speculation_success};
                end
                {EVT_PAGE_WALK, UM_WALK_COUNT}: begin
                    step = {1'b0, walk_go};
                end
                {EVT_PAGE_WALK, UM_WALK_CYCLES}: begin
                    step = {1'b0, walk_on};
                end
                {EVT_FP_COMPUTE, UM_NONE}: begin
                    step = {1'b0, e.float_compute_uop_event & is_zero};
                end
                {EVT_FP_HELP, UM_NONE}: begin
                    step = {1'b0, help & ~is_zero};
                end
                {EVT_MULTIPLY, UM_NONE}: begin
                    step = {1'b0, e.multiply_event_int} +
                           {1'b0, e.multiply_event_float};
                end
                default: begin
                    step = 2'h0;
                end
            endcase
        end
        return step;
    endfunction : event_increment

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTR; gi++) begin : g_ctr
            localparam logic IS_ZERO = (gi == CTR_ZERO_IDX);

            assign inc[gi] = event_increment(counter_select[gi], IS_ZERO, events,
                                             walk_busy_reg, walk_start, disamb_busy_reg,
                                             float_microcode_help_event);

            // counters wrap silently; overflow handling lives elsewhere
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    ctr_reg[gi] <= CTR_RESET;
                end else begin
                    ctr_reg[gi] <= ctr_reg[gi] + CTR_W'(inc[gi]);
                end
            end

            assign count_value[gi] = ctr_reg[gi];

            chk_store_miss_count: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (counter_select[gi].enable && counter_select[gi].event_code == EVT_DTLB_MISS
                 && counter_select[gi].unit_mask == UM_STORE_MISS
                 && events.store_translation_miss_event)
                |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                else $error("store miss did not advance counter");

            chk_disamb_cycles: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (counter_select[gi].enable && counter_select[gi].event_code == EVT_DISAMBIG
                 && counter_select[gi].unit_mask == UM_DIS_RESET)
                |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'($past(disamb_busy_reg))))
                else $error("disambiguation cycles miscounted");

            chk_disamb_success: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (counter_select[gi].enable && counter_select[gi].event_code == EVT_DISAMBIG
                 && counter_select[gi].unit_mask == UM_DIS_SUCCESS)
                |=> (ctr_reg[gi] - $past(ctr_reg[gi])
                     == CTR_W'($past(events.load_order_speculation_success))))
                else $error("disambiguation success miscounted");

            chk_walk_starts: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (counter_select[gi].enable && counter_select[gi].event_code == EVT_PAGE_WALK
                 && counter_select[gi].unit_mask == UM_WALK_COUNT
                 && (events.walk_start_dtlb || events.walk_start_itlb))
                |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                else $error("page walk start not counted");

            chk_walk_cycles: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (counter_select[gi].enable && counter_select[gi].event_code == EVT_PAGE_WALK
                 && counter_select[gi].unit_mask == UM_WALK_CYCLES && walk_busy_reg)
                |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                else $error("page walk cycle not counted");

            chk_multiply_count: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (counter_select[gi].enable && counter_select[gi].event_code == EVT_MULTIPLY
                 && counter_select[gi].unit_mask == UM_NONE
                 && events.multiply_event_int && events.multiply_event_float)
                |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(2)))
                else $error("two multiplies did not add two");

            chk_disabled_stable: assert property (
                @(posedge ref_clk) disable iff (!rst_b)
                (!counter_select[gi].enable) |=> $stable(ctr_reg[gi]))
                else $error("disabled counter moved");

            if (gi == CTR_ZERO_IDX) begin : g_zero
                chk_help_not_zero: assert property (
                    @(posedge ref_clk) disable iff (!rst_b)
                    (counter_select[gi].event_code == EVT_FP_HELP
                     && counter_select[gi].unit_mask == UM_NONE)
                    |=> $stable(ctr_reg[gi]))
                    else $error("assist event advanced counter zero");
                chk_fp_uop_zero: assert property (
                    @(posedge ref_clk) disable iff (!rst_b)
                    (counter_select[gi].enable && counter_select[gi].event_code == EVT_FP_COMPUTE
                     && counter_select[gi].unit_mask == UM_NONE
                     && events.float_compute_uop_event)
                    |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                    else $error("float uop not counted on counter zero");
            end else begin : g_other
                chk_fp_uop_other: assert property (
                    @(posedge ref_clk) disable iff (!rst_b)
                    (counter_select[gi].event_code == EVT_FP_COMPUTE
                     && counter_select[gi].unit_mask == UM_NONE)
                    |=> $stable(ctr_reg[gi]))
                    else $error("float uop advanced wrong counter");
                chk_help_vector: assert property (
                    @(posedge ref_clk) disable iff (!rst_b)
                    (counter_select[gi].enable && counter_select[gi].event_code == EVT_FP_HELP
                     && counter_select[gi].unit_mask == UM_NONE
                     && events.vec_denormal_input && !events.denormal_input_zeroing_flag)
                    |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                    else $error("vector denormal assist not counted");
                chk_help_underflow: assert property (
                    @(posedge ref_clk) disable iff (!rst_b)
                    (counter_select[gi].enable && counter_select[gi].event_code == EVT_FP_HELP
                     && counter_select[gi].unit_mask == UM_NONE
                     && events.vec_underflow_result && !events.underflow_result_zeroing_flag)
                    |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                    else $error("vector underflow assist not counted");
                chk_help_stack: assert property (
                    @(posedge ref_clk) disable iff (!rst_b)
                    (counter_select[gi].enable && counter_select[gi].event_code == EVT_FP_HELP
                     && counter_select[gi].unit_mask == UM_NONE
                     && events.stack_divide_by_zero)
                    |=> (ctr_reg[gi] == $past(ctr_reg[gi]) + CTR_W'(1)))
                    else $error("stack assist not counted");
            end
        end
    endgenerate

    chk_flush_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (events.disamb_mispredict && !$past(events.disamb_mispredict))
        |=> (pipe_flush && restart_load_id == $past(events.disamb_load_id)))
        else $error("mispredict did not flush with its load id");

    chk_flush_cause: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        pipe_flush |-> $past(events.disamb_mispredict))
        else $error("flush without mispredict");

    chk_disamb_window: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (events.disamb_mispredict ##1 (!events.disamb_restart_done
                                       && !events.disamb_mispredict) [*2])
        |-> disamb_busy_reg)
        else $error("recovery window closed early");

    chk_disamb_close: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (events.disamb_restart_done && !events.disamb_mispredict) |=> !disamb_busy)
        else $error("recovery window did not close");

    // a burst flushes every cycle, each cycle with its own load id
    chk_flush_every: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        events.disamb_mispredict
        |=> (pipe_flush && restart_load_id == $past(events.disamb_load_id)))
        else $error("mispredict cycle without matching flush");

    // start wins over done, so only a lone done may close the window
    chk_walk_open: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (events.walk_start_dtlb || events.walk_start_itlb)
        |=> walk_busy)
        else $error("page walk window did not open");

    chk_walk_close: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (events.walk_done && !events.walk_start_dtlb && !events.walk_start_itlb)
        |=> !walk_busy)
        else $error("page walk window did not close");

endmodule : perf_event_select_decoder

// ===== test/core_event_source.sv
/*
 * Partner model of the pipeline, translation and float event sources.
 * Turns a one-cycle request kind from the bench into core event strobes.
 * Assumes go and kind change just after a rising edge of the core clock.
 */
`timescale 1ns/1ns

module core_event_source
    import perf_event_pkg::*;
(
    input  logic         go,
    input  logic [4:0]   kind,
    input  logic [7:0]   load_id,
    output core_events_t events
);
    always_comb begin
        events = '0;
        // id only valid beside a mispredict; otherwise never the stale value
        events.disamb_load_id = ~load_id;
        if (go) begin
            case (kind)
                5'd0:  events.store_translation_miss_event   = 1'b1;
                5'd1:  events.load_order_speculation_success = 1'b1;
                5'd2:  events.walk_start_dtlb                = 1'b1;
                5'd3:  events.walk_start_itlb                = 1'b1;
                5'd4:  events.walk_done                      = 1'b1;
                5'd5:  events.float_compute_uop_event        = 1'b1;
                5'd6:  events.vec_denormal_input             = 1'b1;
                5'd7:  events.vec_underflow_result           = 1'b1;
                5'd8:  events.stack_nan_or_denormal_load     = 1'b1;
                5'd9:  events.stack_divide_by_zero           = 1'b1;
                5'd10: events.stack_underflow_output         = 1'b1;
                5'd11: events.multiply_event_int             = 1'b1;
                5'd12: events.multiply_event_float           = 1'b1;
                5'd13: begin
                    events.multiply_event_int   = 1'b1;
                    events.multiply_event_float = 1'b1;
                end
                5'd14: begin
                    events.vec_denormal_input          = 1'b1;
                    events.denormal_input_zeroing_flag = 1'b1;
                end
                5'd15: begin
                    events.vec_underflow_result          = 1'b1;
                    events.underflow_result_zeroing_flag = 1'b1;
                end
                5'd16: begin
                    events.disamb_mispredict = 1'b1;
                    events.disamb_load_id    = load_id;
                end
                5'd17: events.disamb_restart_done = 1'b1;
                default: begin
                end
            endcase
        end
    end
endmodule : core_event_source

// ===== test/tb_top.sv
/*
 * Self-checking bench for the event selector: a row table of one-cycle
 * strobes against both counters, then hand tests of the two windows,
 * the flush and a mid-run reset.
 * Assumes a 100 MHz core clock and the partner model for the strobes.
 */
`timescale 1ns/1ns

module tb_top;
    import perf_event_pkg::*;

    typedef struct {
        logic [7:0] code;
        logic [7:0] mask;
        logic       en;
        logic [4:0] kind;
        logic [1:0] d0;
        logic [1:0] d1;
    } row_t;

    logic                          ref_clk;
    logic                          rst_b;
    logic                          go;
    logic [4:0]                    kind;
    logic [7:0]                    load_id;
    ctr_sel_t [NUM_CTR-1:0]        counter_select;
    core_events_t                  events;
    logic [NUM_CTR-1:0][CTR_W-1:0] count_value;
    logic                          pipe_flush;
    logic [ID_W-1:0]               restart_load_id;
    logic                          disamb_busy;
    logic                          walk_busy;
    logic [CTR_W-1:0]              base0;
    logic [CTR_W-1:0]              base1;
    int                            bad_count;
    int                            compares;
    int                            cycles;

    // code, mask, enable, kind, step on counter zero, step on counter one
    row_t rows [19] = '{
        '{8'h08, 8'h08, 1'b1, 5'd0,  2'd1, 2'd1},
        '{8'h08, 8'h08, 1'b0, 5'd0,  2'd0, 2'd0},
        '{8'h08, 8'h01, 1'b1, 5'd0,  2'd0, 2'd0},
        '{8'h09, 8'h02, 1'b1, 5'd1,  2'd1, 2'd1},
        '{8'h09, 8'h02, 1'b1, 5'd0,  2'd0, 2'd0},
        '{8'h0C, 8'h01, 1'b1, 5'd2,  2'd1, 2'd1},
        '{8'h0C, 8'h01, 1'b1, 5'd3,  2'd1, 2'd1},
        '{8'h0C, 8'h01, 1'b1, 5'd4,  2'd0, 2'd0},
        '{8'h10, 8'h00, 1'b1, 5'd5,  2'd1, 2'd0},
        '{8'h11, 8'h00, 1'b1, 5'd6,  2'd0, 2'd1},
        '{8'h11, 8'h00, 1'b1, 5'd7,  2'd0, 2'd1},
        '{8'h11, 8'h00, 1'b1, 5'd8,  2'd0, 2'd1},
        '{8'h11, 8'h00, 1'b1, 5'd9,  2'd0, 2'd1},
        '{8'h11, 8'h00, 1'b1, 5'd10, 2'd0, 2'd1},
        '{8'h11, 8'h00, 1'b1, 5'd14, 2'd0, 2'd0},
        '{8'h11, 8'h00, 1'b1, 5'd15, 2'd0, 2'd0},
        '{8'h12, 8'h00, 1'b1, 5'd11, 2'd1, 2'd1},
        '{8'h12, 8'h00, 1'b1, 5'd12, 2'd1, 2'd1},
        '{8'h12, 8'h00, 1'b1, 5'd13, 2'd2, 2'd2}
    };

    core_event_source src (
        .go      (go),
        .kind    (kind),
        .load_id (load_id),
        .events  (events)
    );

    perf_event_select_decoder uut (
        .ref_clk         (ref_clk),
        .rst_b           (rst_b),
        .counter_select  (counter_select),
        .events          (events),
        .count_value     (count_value),
        .pipe_flush      (pipe_flush),
        .restart_load_id (restart_load_id),
        .disamb_busy     (disamb_busy),
        .walk_busy       (walk_busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [CTR_W-1:0] seen,
                       input logic [CTR_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic step(input logic g, input logic [4:0] k);
        @(posedge ref_clk);
        go   <= g;
        kind <= k;
    endtask : step

    // selection lands on an idle edge, then both bases are taken
    task automatic set_pair(input ctr_sel_t s0, input ctr_sel_t s1);
        @(posedge ref_clk);
        counter_select[0] <= s0;
        counter_select[1] <= s1;
        @(posedge ref_clk);
        #1;
        base0 = count_value[0];
        base1 = count_value[1];
    endtask : set_pair

    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ceiling well above the roughly 95 cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        rst_b          = 1'b0;
        go             = 1'b0;
        kind           = 5'd0;
        load_id        = 8'h05;
        counter_select = '0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        chk("count0 reset", count_value[0], CTR_RESET);
        chk("count1 reset", count_value[1], CTR_RESET);
        chk("flush reset", {39'h0, pipe_flush}, 40'h0);
        chk("id reset", {32'h0, restart_load_id}, {32'h0, ID_RESET});
        foreach (rows[i]) begin
            set_pair('{rows[i].en, rows[i].code, rows[i].mask},
                     '{rows[i].en, rows[i].code, rows[i].mask});
            step(1'b1, rows[i].kind);
            step(1'b0, 5'd0);
            #1;
            chk("count0 row", count_value[0], base0 + rows[i].d0);
            chk("count1 row", count_value[1], base1 + rows[i].d1);
        end
        set_pair('{1'b1, EVT_DISAMBIG, UM_DIS_RESET}, '{1'b1, EVT_DISAMBIG, UM_DIS_RESET});
        step(1'b1, 5'd16);
        step(1'b0, 5'd0);
        #1;
        chk("flush on", {39'h0, pipe_flush}, 40'h1);
        chk("disamb busy", {39'h0, disamb_busy}, 40'h1);
        chk("restart id", {32'h0, restart_load_id}, 40'h5);
        step(1'b0, 5'd0);
        #1;
        chk("flush off", {39'h0, pipe_flush}, 40'h0);
        step(1'b1, 5'd17);
        step(1'b0, 5'd0);
        #1;
        chk("disamb idle", {39'h0, disamb_busy}, 40'h0);
        chk("reset cycles", count_value[0], base0 + 40'h3);
        set_pair('{1'b1, EVT_PAGE_WALK, UM_WALK_CYCLES}, '{1'b1, EVT_PAGE_WALK, UM_WALK_COUNT});
        step(1'b1, 5'd2);
        step(1'b0, 5'd0);
        #1;
        chk("walk busy", {39'h0, walk_busy}, 40'h1);
        step(1'b1, 5'd4);
        step(1'b0, 5'd0);
        #1;
        chk("walk idle", {39'h0, walk_busy}, 40'h0);
        chk("walk cycles", count_value[0], base0 + 40'h2);
        chk("walk count", count_value[1], base1 + 40'h1);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        chk("count0 rerun", count_value[0], CTR_RESET);
        chk("count1 rerun", count_value[1], CTR_RESET);
        end_sim();
    end
endmodule : tb_top
